// ==== hw/vof_cfg.svh ====
`ifndef VOF_CFG_SVH
`define VOF_CFG_SVH
// pipeline and flush
`define VOF_PIPE_DEPTH 6
`define VOF_FLUSH_SETS 3'h6
// sampling phase steps over one full pixel period
`define VOF_PHASE_STEPS 32
// fixed test clock rate fed on testClk
`define VOF_TEST_CLK_MHZ 40
// format select codes
`define VOF_FMT_SEL_444 2'h0
`define VOF_FMT_SEL_422 2'h1
`define VOF_FMT_SEL_DDR 2'h2
// output clock source codes
`define VOF_CLK_SEL_PIX 2'h0
`define VOF_CLK_SEL_90 2'h1
`define VOF_CLK_SEL_2X 2'h2
`define VOF_CLK_SEL_TEST 2'h3
// reset values of the settings
`define VOF_RST_HS_WIDTH 8'h20
`define VOF_RST_HOLD_LEAD 8'h02
`define VOF_RST_HOLD_TRAIL 8'h0A
`endif

// ==== hw/vof_pkg.sv ====
`include "vof_cfg.svh"
package vof_pkg;
  // settings carried from the control domain
  typedef struct packed {
    logic [1:0] fmtSel;
    logic hsPolHigh;
    logic [7:0] hsWidth;
    logic [7:0] holdLead;
    logic [7:0] holdTrail;
    logic useExtHold;
    logic [1:0] vsSrc;
    logic [1:0] clkSel;
    logic clkInv;
    logic [4:0] phase;
  } cfg_t;
  typedef enum logic [2:0] {
    FMT_444 = 3'b001,
    FMT_422 = 3'b010,
    FMT_DDR = 3'b100
  } fmt_t;
  typedef struct packed {
    logic [23:0] data;
    logic lead;
  } stage_t;
  // control domain state
  typedef struct packed {
    cfg_t held;
    logic reqT;
    logic ackS1;
    logic ackS2;
  } sys_t;
  // pixel domain state
  typedef struct packed {
    logic reqS1, reqS2, reqS3;
    cfg_t cfg;
    fmt_t fmt;
    logic hsS1, hsS2, hsD;
    logic [3:0] vsS1, vsS2;
    logic vsD;
    logic hoS1, hoS2;
    logic [11:0] runLen, highLen, lowLen;
    logic polHigh;
    logic [11:0] lineCnt, linesPerFrame;
    logic holdInt;
    stage_t [`VOF_PIPE_DEPTH-1:0] pipe;
    logic [7:0] hsCnt;
    logic hsync_output;
    logic chromaOdd;
    logic [23:0] rise, fall;
    logic [2:0] setCnt;
    logic valid;
  } pix_t;
endpackage

// ==== hw/video_output_sync_formatter.sv ====
`timescale 1ns/1ps
`include "vof_cfg.svh"
module video_output_sync_formatter (
  input wire logic clk,
  input wire logic rst_n,
  input wire vof_pkg::cfg_t ctrl,
  input wire logic pixClk,
  input wire logic pixClk90,
  input wire logic pixClk2x,
  input wire logic testClk,
  input wire logic [23:0] pixelIn,
  input wire logic hsyncIn,
  input wire logic [3:0] vsyncIn,
  input wire logic externalHold,
  output logic outputDataClock,
  output logic [7:0] redOut,
  output logic [7:0] greenOut,
  output logic [7:0] blueOut,
  output logic hsyncOutput,
  output logic dataValid,
  output logic pllHold,
  output logic pllRef,
  output logic [4:0] samplePhase,
  output logic hsyncPolarityHigh
);

  localparam vof_pkg::cfg_t CFG_RST = '{
    fmtSel: `VOF_FMT_SEL_444, hsPolHigh: 1'b1,
    hsWidth: `VOF_RST_HS_WIDTH, holdLead: `VOF_RST_HOLD_LEAD,
    holdTrail: `VOF_RST_HOLD_TRAIL, useExtHold: 1'b0, vsSrc: 2'h0,
    clkSel: `VOF_CLK_SEL_PIX, clkInv: 1'b0, phase: 5'h00};

  // ****************************************************
  // format decoding
  // ****************************************************
  function automatic vof_pkg::fmt_t decodeFmt(input logic [1:0] sel);
    unique case (sel)
      `VOF_FMT_SEL_422: decodeFmt = vof_pkg::FMT_422;
      `VOF_FMT_SEL_DDR: decodeFmt = vof_pkg::FMT_DDR;
      default: decodeFmt = vof_pkg::FMT_444;
    endcase
  endfunction

  // ****************************************************
  // control domain: settings handshake toward the link
  // ****************************************************
  vof_pkg::sys_t sys;
  vof_pkg::sys_t next_sys;
  vof_pkg::pix_t st;
  vof_pkg::pix_t next_st;

  // new settings are launched only when the last toggle was acknowledged
  always_comb begin
    next_sys = sys;
    next_sys.ackS1 = st.reqS3;
    next_sys.ackS2 = sys.ackS1;
    if (sys.reqT == sys.ackS2 && ctrl != sys.held) begin
      next_sys.held = ctrl;
      next_sys.reqT = ~sys.reqT;
    end
  end

  // control domain registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys <= '{held: CFG_RST, reqT: 1'b0, ackS1: 1'b0, ackS2: 1'b0};
    end else begin
      sys <= next_sys;
    end
  end

  // ****************************************************
  // link domain reset: async assert, sync release
  // ****************************************************
  logic [1:0] pixRstSync;
  logic pixRst_n;
  always_ff @(posedge pixClk or negedge rst_n) begin
    if (!rst_n) begin
      pixRstSync <= 2'h0;
    end else begin
      pixRstSync <= {pixRstSync[0], 1'b1};
    end
  end
  assign pixRst_n = pixRstSync[1];

  // ****************************************************
  // link domain: sync, hold window, pipeline, formatter
  // ****************************************************
  logic hsEdge;
  logic hsLead;
  logic vsSel;
  logic vsLead;
  logic odd;
  logic [7:0] chroma;
  vof_pkg::stage_t o;

  always_comb begin
    next_st = st;
    // settings crossing: held word is stable while the toggle is open
    next_st.reqS1 = sys.reqT;
    next_st.reqS2 = st.reqS1;
    next_st.reqS3 = st.reqS2;
    if (st.reqS2 != st.reqS3) begin
      next_st.cfg = sys.held;
    end
    // pin synchronisers
    next_st.hsS1 = hsyncIn;
    next_st.hsS2 = st.hsS1;
    next_st.hsD = st.hsS2;
    next_st.vsS1 = vsyncIn;
    next_st.vsS2 = st.vsS1;
    next_st.hoS1 = externalHold;
    next_st.hoS2 = st.hoS1;
    // polarity: the shorter level of the line is the sync pulse
    hsEdge = st.hsS2 != st.hsD;
    if (hsEdge) begin
      if (st.hsD) begin
        next_st.highLen = st.runLen;
      end else begin
        next_st.lowLen = st.runLen;
      end
      next_st.runLen = 12'h001;
    end else if (st.runLen != 12'hFFF) begin
      next_st.runLen = st.runLen + 12'h001;
    end
    next_st.polHigh = st.highLen < st.lowLen;
    hsLead = hsEdge && (st.hsS2 == st.polHigh);
    // vsync source and frame boundary
    vsSel = st.vsS2[st.cfg.vsSrc];
    next_st.vsD = vsSel;
    vsLead = vsSel && !st.vsD;
    if (vsLead) begin
      next_st.fmt = decodeFmt(st.cfg.fmtSel);
    end
    // internal hold window counted in lines around vsync
    if (vsLead) begin
      next_st.linesPerFrame = st.lineCnt;
      next_st.lineCnt = 12'h000;
      if (st.cfg.holdLead == 8'h00) begin
        next_st.holdInt = 1'b1;
      end
      if (st.cfg.holdTrail == 8'h00) begin
        next_st.holdInt = 1'b0;
      end
    end else if (hsLead) begin
      next_st.lineCnt = st.lineCnt + 12'h001;
      if (next_st.lineCnt == {4'h0, st.cfg.holdTrail}) begin
        next_st.holdInt = 1'b0;
      end
      if (st.cfg.holdLead != 8'h00 &&
          12'(st.linesPerFrame - st.lineCnt - 12'h001) == {4'h0, st.cfg.holdLead}) begin
        next_st.holdInt = 1'b1;
      end
    end
    // data and hsync lead share one pipeline
    next_st.pipe[0] = '{data: pixelIn, lead: hsLead};
    for (int i = 1; i < `VOF_PIPE_DEPTH; i++) begin
      next_st.pipe[i] = st.pipe[i-1];
    end
    o = st.pipe[`VOF_PIPE_DEPTH-1];
    // hsync output pulse width in pixel clocks
    if (o.lead) begin
      next_st.hsCnt = st.cfg.hsWidth;
    end else if (st.hsCnt != 8'h00) begin
      next_st.hsCnt = st.hsCnt - 8'h01;
    end
    // level follows the settings word that lands in the same cycle, so a polarity
    // change never leaves the pulse at the old active level for a cycle
    next_st.hsync_output = (next_st.hsCnt != 8'h00) ? next_st.cfg.hsPolHigh
                                              : ~next_st.cfg.hsPolHigh;
    // chroma phase restarts on each line so Cb comes first
    odd = o.lead ? 1'b0 : st.chromaOdd;
    next_st.chromaOdd = ~odd;
    chroma = odd ? o.data[23:16] : o.data[7:0];
    unique case (st.fmt)
      vof_pkg::FMT_444: begin
        next_st.rise = o.data;
        next_st.fall = o.data;
      end
      vof_pkg::FMT_422: begin
        next_st.rise = {chroma, o.data[15:8], chroma};
        next_st.fall = {chroma, o.data[15:8], o.data[15:8]};
      end
      vof_pkg::FMT_DDR: begin
        next_st.rise = {o.data[11:0], 4'h0, chroma};
        next_st.fall = {o.data[23:12], 4'h0, o.data[15:8]};
      end
      default: begin
        next_st.rise = 24'h000000;
        next_st.fall = 24'h000000;
      end
    endcase
    // flush count of presented sets
    if (st.setCnt != `VOF_FLUSH_SETS) begin
      next_st.setCnt = st.setCnt + 3'h1;
    end
    next_st.valid = st.setCnt == `VOF_FLUSH_SETS;
  end

  // link domain registers
  always_ff @(posedge pixClk or negedge pixRst_n) begin
    if (!pixRst_n) begin
      st <= '0;
      st.cfg <= CFG_RST;
      st.fmt <= vof_pkg::FMT_444;
      st.hsync_output <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************
  // pins: ddr output stage, clock select, hold
  // ****************************************************
  // first half of a pixel shows the rise word, second half the fall word
  assign redOut = pixClk ? st.rise[23:16] : st.fall[23:16];
  assign greenOut = pixClk ? st.rise[15:8] : st.fall[15:8];
  assign blueOut = pixClk ? st.rise[7:0] : st.fall[7:0];
  assign hsyncOutput = st.hsync_output;
  assign dataValid = st.valid;
  assign samplePhase = st.cfg.phase;
  assign hsyncPolarityHigh = st.polHigh;

  // base clock is inverted so its rising edge falls mid data eye
  always_comb begin
    unique case (st.cfg.clkSel)
      `VOF_CLK_SEL_PIX: outputDataClock = ~pixClk ^ st.cfg.clkInv;
      `VOF_CLK_SEL_90: outputDataClock = ~pixClk90 ^ st.cfg.clkInv;
      `VOF_CLK_SEL_2X: outputDataClock = ~pixClk2x ^ st.cfg.clkInv;
      default: outputDataClock = ~testClk ^ st.cfg.clkInv;
    endcase
  end

  // hold source select and reference gating
  assign pllHold = st.cfg.useExtHold ? st.hoS2 : st.holdInt;
  assign pllRef = st.hsS2 & ~pllHold;

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge pixClk);
  endclocking
  default disable iff (!pixRst_n);

  sequence hsBegin;
    st.pipe[`VOF_PIPE_DEPTH-1].lead;
  endsequence

  sequence ddrFrame;
    st.fmt == vof_pkg::FMT_DDR;
  endsequence

  flush_six_a: assert property ($rose(st.valid) |-> $past(st.setCnt) == 3'h6)
    else $error("data flagged valid before six sets");
  hs_width_a: assert property (hsBegin |=> st.hsCnt == $past(st.cfg.hsWidth))
    else $error("hsync pulse width not loaded");
  hs_level_a: assert property (st.hsCnt != 8'h00 |-> st.hsync_output == st.cfg.hsPolHigh)
    else $error("hsync output at wrong level");
  hold_gate_a: assert property (pllHold |-> !pllRef)
    else $error("pll reference passed during hold");
  hold_src_a: assert property (!st.cfg.useExtHold && st.holdInt |-> pllHold)
    else $error("internal hold window ignored");
  fmt_frame_a: assert property ($changed(st.fmt) |-> $past(vsLead))
    else $error("format changed inside a frame");
  cb_first_a: assert property ((st.fmt == vof_pkg::FMT_422) and hsBegin
      |=> st.rise[23:16] == $past(o.data[7:0]))
    else $error("first chroma of line is not Cb");
  ddr_split_a: assert property (ddrFrame |=> st.rise[23:12] == $past(o.data[11:0])
      && st.fall[23:12] == $past(o.data[23:12]))
    else $error("ddr halves misplaced");
  ddr_unused_a: assert property (ddrFrame |=> st.rise[11:8] == 4'h0
      && st.fall[11:8] == 4'h0)
    else $error("unused green pins toggling");
  trail_drop_a: assert property (vsLead && !st.cfg.useExtHold
      && st.cfg.holdTrail == 8'h00 |=> !st.holdInt)
    else $error("hold window not dropped");

  // one hsync lead that is not also a frame start
  sequence lineStart;
    hsLead && !vsLead;
  endsequence

  // lead marker rides the data pipeline to its last stage
  pipe_lead_a: assert property (hsLead |-> ##6 hsBegin)
    else $error("hsync lead lost in pipeline");

  // pulse starts together with the pixel that carried the lead
  hs_start_a: assert property (hsBegin and (st.cfg.hsWidth != 8'h00)
      |=> st.hsync_output == st.cfg.hsPolHigh)
    else $error("hsync output did not start with its pixel");

  // with no count running the output rests at the inactive level
  hs_idle_a: assert property (st.hsCnt == 8'h00
      |-> st.hsync_output != st.cfg.hsPolHigh)
    else $error("hsync output active while idle");

  // the pulse counter steps down once per pixel clock
  hs_count_a: assert property (st.hsCnt != 8'h00 && !st.pipe[`VOF_PIPE_DEPTH-1].lead
      |=> st.hsCnt == $past(st.hsCnt) - 8'h01)
    else $error("hsync pulse counter skipped");

  // valid stays up once the flush is over
  valid_stay_a: assert property (st.valid |=> st.valid)
    else $error("data valid dropped");

  // valid never shows before the flush count is reached
  valid_early_a: assert property (st.setCnt != `VOF_FLUSH_SETS |-> !st.valid)
    else $error("data valid during flush");

  // a zero lead count raises the window at the vsync edge itself
  lead_zero_a: assert property (vsLead && st.cfg.holdLead == 8'h00
      && st.cfg.holdTrail != 8'h00 |=> st.holdInt)
    else $error("hold window not raised at vsync");

  // window drops on the line that reaches the trail count
  trail_hit_a: assert property (lineStart ##0
      (12'(st.lineCnt + 12'h001) == {4'h0, st.cfg.holdTrail}
      && 12'(st.linesPerFrame - st.lineCnt - 12'h001) != {4'h0, st.cfg.holdLead})
      |=> !st.holdInt)
    else $error("hold window kept past trail count");

  // window rises the lead count of lines ahead of the next vsync
  lead_hit_a: assert property (lineStart ##0 (st.cfg.holdLead != 8'h00
      && 12'(st.linesPerFrame - st.lineCnt - 12'h001) == {4'h0, st.cfg.holdLead})
      |=> st.holdInt)
    else $error("hold window not raised ahead of vsync");

  // plain 4:4:4 shows the whole pixel in both halves
  full_444_a: assert property (st.fmt == vof_pkg::FMT_444
      |=> st.rise == $past(o.data) && st.fall == $past(o.data))
    else $error("4:4:4 word split");

  // 4:2:2 keeps luma on green for the whole pixel
  luma_green_a: assert property (st.fmt == vof_pkg::FMT_422
      |=> st.rise[15:8] == $past(o.data[15:8])
      && st.fall[15:8] == $past(o.data[15:8]))
    else $error("luma missing from green");

  // secondary channel: chroma first half, luma second half
  blue_ddr_a: assert property (st.fmt != vof_pkg::FMT_444
      |=> st.rise[7:0] == $past(chroma)
      && st.fall[7:0] == $past(o.data[15:8]))
    else $error("secondary channel out of order");

  // chroma phase alternates on every pixel inside a line
  chroma_alt_a: assert property (!st.pipe[`VOF_PIPE_DEPTH-1].lead
      |=> st.chromaOdd != $past(st.chromaOdd))
    else $error("chroma phase did not alternate");

endmodule // video_output_sync_formatter

// ==== verif/display_sink.sv ====
`timescale 1ns/1ps
// ************
// display sink
// ************
module display_sink (
  input wire logic dataClock,
  input wire logic [7:0] red,
  input wire logic [7:0] green,
  input wire logic [7:0] blue,
  output logic [23:0] word
);
  // latch the pins on the rising output clock edge
  always_ff @(posedge dataClock) begin
    word <= {red, green, blue};
  end
endmodule // display_sink

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`include "vof_cfg.svh"
module tb_top;
  // ************
  // signals
  // ************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pixClk = 1'b0;
  logic pixClk90 = 1'b0;
  logic pixClk2x = 1'b0;
  logic testClk = 1'b0;
  vof_pkg::cfg_t ctrl;
  vof_pkg::cfg_t cfgNew;
  logic [23:0] pixelIn = 24'h0;
  logic hsyncIn = 1'b1;
  logic [3:0] vsyncIn = 4'h0;
  logic externalHold = 1'b0;
  logic outputDataClock, hsyncOutput, dataValid, pllHold, pllRef, polHigh;
  logic [7:0] redOut, greenOut, blueOut;
  logic [4:0] samplePhase;
  logic [23:0] seenWord, p;
  logic [23:0] hist [16];
  logic [31:0] rnd;
  logic [1:0] vsSel;
  logic prevKind, kind, havePrev;
  integer seed = 32'h0F4FCBDC;
  integer miscompares = 0;
  integer nChecks = 0;
  integer px = 0, ln = 0, edgeCnt = 0, mode = 0, hsRun = 0, hsSeen = 0, i, r;

  video_output_sync_formatter video_output_sync_formatter_inst (
    .clk(clk), .rst_n(rst_n), .ctrl(ctrl), .pixClk(pixClk), .pixClk90(pixClk90),
    .pixClk2x(pixClk2x), .testClk(testClk), .pixelIn(pixelIn), .hsyncIn(hsyncIn),
    .vsyncIn(vsyncIn), .externalHold(externalHold), .outputDataClock(outputDataClock),
    .redOut(redOut), .greenOut(greenOut), .blueOut(blueOut), .hsyncOutput(hsyncOutput),
    .dataValid(dataValid), .pllHold(pllHold), .pllRef(pllRef), .samplePhase(samplePhase),
    .hsyncPolarityHigh(polHigh));
  display_sink display_sink_inst (
    .dataClock(outputDataClock), .red(redOut), .green(greenOut), .blue(blueOut),
    .word(seenWord));

  // control clock, then the link clocks with their own phase
  always #5 clk = ~clk;
  initial begin
    #2;
    fork
      forever #15 pixClk = ~pixClk;
      begin #7.5; forever #15 pixClk90 = ~pixClk90; end
      forever #7.5 pixClk2x = ~pixClk2x;
      forever #12.5 testClk = ~testClk;
    join
  end

  // video source: 40 pixels by 16 lines, hsync active low, random pixels
  always @(negedge pixClk) begin
    px = (px == 39) ? 0 : px + 1;
    if (px == 0) ln = (ln == 15) ? 0 : ln + 1;
    hsyncIn = (px >= 4);
    vsyncIn = (ln < 2) ? (4'h1 << vsSel) : 4'h0;
    rnd = $random(seed);
    pixelIn = {~rnd[7:0], rnd[15:0]};
  end

  // ************
  // checking
  // ************
  task automatic tally(input string w, input logic [23:0] e, input logic [23:0] g);
    nChecks = nChecks + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("unexpected %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chkWord(input string w, input logic [23:0] e, input logic [23:0] g);
    tally(w, e, g);
  endtask
  task automatic chkByte(input string w, input logic [7:0] e, input logic [7:0] g);
    tally(w, {16'h0, e}, {16'h0, g});
  endtask
  task automatic chkBit(input string w, input logic e, input logic g);
    tally(w, {23'h0, e}, {23'h0, g});
  endtask
  task automatic waitLine(input integer l);
    do @(posedge pixClk); while (!(ln == l && px == 35));
  endtask
  function automatic logic expClk(input logic [2:0] c);
    logic s;
    case (c[1:0])
      `VOF_CLK_SEL_PIX: s = pixClk;
      `VOF_CLK_SEL_90: s = pixClk90;
      `VOF_CLK_SEL_2X: s = pixClk2x;
      default: s = testClk;
    endcase
    return ~s ^ c[2];
  endfunction
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // pixel history, hsync pulse length, pins in the high then the low half
  always @(posedge pixClk) begin
    hist[edgeCnt % 16] = pixelIn;
    edgeCnt = edgeCnt + 1;
    if (hsyncOutput === ctrl.hsPolHigh) begin
      hsRun = hsRun + 1;
    end else begin
      if (hsRun != 0) hsSeen = hsRun;
      hsRun = 0;
    end
    #5;
    p = hist[(edgeCnt - 7) % 16];
    if (mode == 2) begin
      kind = (redOut === p[23:16]);
      chkBit("redChroma", 1'b1, kind | (redOut === p[7:0]));
      if (havePrev) chkBit("chromaOrder", ~prevKind, kind);
      chkByte("greenLuma", p[15:8], greenOut);
    end
    havePrev = (mode == 2);
    prevKind = kind;
    if (mode >= 2) chkBit("blueChroma", 1'b1, blueOut === p[7:0] || blueOut === p[23:16]);
    if (mode == 3) chkByte("redRise", p[11:4], redOut);
    if (mode == 3) chkByte("greenRise", {p[3:0], 4'h0}, greenOut);
    @(negedge pixClk);
    #5;
    if (mode == 1) chkWord("sinkWord", p, seenWord);
    if (mode >= 2) chkByte("blueLuma", p[15:8], blueOut);
    if (mode == 3) chkByte("redFall", p[23:16], redOut);
    if (mode == 3) chkByte("greenFall", {p[15:12], 4'h0}, greenOut);
  end

  // ************
  // main sequence
  // ************
  initial begin
    vsSel = 2'($random(seed));
    ctrl = '{fmtSel: 2'h0, hsPolHigh: 1'b1, hsWidth: 8'h20, holdLead: 8'h02,
             holdTrail: 8'h0A, useExtHold: 1'b0, vsSrc: vsSel, clkSel: 2'h0,
             clkInv: 1'b0, phase: 5'h00};
    repeat (5) @(posedge clk);
    chkBit("dataValid", 1'b0, dataValid);
    chkByte("redOut", 8'h00, redOut);
    @(negedge clk);
    rst_n = 1'b1;
    i = 0;
    while (dataValid !== 1'b1 && i < 30) begin
      @(posedge pixClk);
      #1;
      i = i + 1;
    end
    chkWord("validEdge", 24'(`VOF_FLUSH_SETS + 3), 24'(i));
    repeat (2) waitLine(5);
    for (r = 0; r < 4; r++) begin
      waitLine(5);
      @(negedge clk);
      cfgNew = ctrl;
      cfgNew.fmtSel = r[1:0];
      cfgNew.hsPolHigh = 1'($random(seed));
      cfgNew.hsWidth = 8'(1 + {$random(seed)} % 16);
      cfgNew.phase = 5'($random(seed));
      ctrl = cfgNew;
      waitLine(15);
      mode = 0;
      waitLine(3);
      mode = (r == 1) ? 2 : (r == 2) ? 3 : 1;
      waitLine(5);
      chkWord("hsyncWidth", {16'h0, ctrl.hsWidth}, 24'(hsSeen));
      chkByte("samplePhase", {3'h0, ctrl.phase}, {3'h0, samplePhase});
      chkBit("polarity", 1'b0, polHigh);
      chkBit("hsyncIdle", ~ctrl.hsPolHigh, hsyncOutput);
      chkBit("pllHold", 1'b1, pllHold);
      chkBit("pllRef", 1'b0, pllRef);
      waitLine(12);
      chkBit("pllHold", 1'b0, pllHold);
      waitLine(15);
      chkBit("pllHold", 1'b1, pllHold);
    end
    mode = 0;
    for (r = 0; r < 8; r++) begin
      @(negedge clk);
      cfgNew = ctrl;
      cfgNew.clkSel = r[1:0];
      cfgNew.clkInv = r[2];
      ctrl = cfgNew;
      repeat (12) @(posedge pixClk);
      repeat (6) begin
        @(posedge clk);
        #1;
        chkBit("outputDataClock", expClk(r[2:0]), outputDataClock);
      end
    end
    @(negedge clk);
    cfgNew = ctrl;
    cfgNew.useExtHold = 1'b1;
    ctrl = cfgNew;
    waitLine(5);
    chkBit("pllHold", 1'b0, pllHold);
    @(negedge clk);
    externalHold = 1'b1;
    repeat (4) @(posedge pixClk);
    #1;
    chkBit("pllHold", 1'b1, pllHold);
    chkBit("pllRef", 1'b0, pllRef);
    print_verdict;
  end

  // watchdog at two and a half times the expected run of about 200 us
  initial begin
    #500000;
    miscompares = miscompares + 1;
    print_verdict;
  end
endmodule // tb_top
